// ==== hdl/bda_alu.sv ====
// Behaviour
// RULE_01: decimal adjust adds six to low nibble if above nine or half carry set.
// RULE_02: then adds six to high nibble if above nine or carry set.
// RULE_03: carry set when corrected result passes two bcd digits.
// RULE_04: decimal adjust never clears carry; signed excess flag untouched.
// RULE_05: byte decrement subtracts one, wraps zero to ff, flags unchanged.
// RULE_06: decrement sources: accumulator, working register, direct, pointer indirect.
// RULE_07: decrement of a port reads the output latch, not pins.
// RULE_08: direct decrement opcode is 00010101 followed by the address byte.
// RULE_09: divide accumulator by auxiliary; quotient to accumulator, remainder to auxiliary.
// RULE_10: divide with nonzero divisor clears carry and signed excess flag.
// RULE_11: zero divisor sets signed excess flag and clears carry.
// RULE_12: loop branch decrements with wrap, branches if nonzero, flags unchanged.
// RULE_13: branch target is advanced pc plus sign-extended displacement.
// RULE_14: loop branch operand is working register or direct byte only.
// RULE_15: divide writes accumulator and auxiliary together at completion.
module bda_alu
  import bda_pkg::*;
#(
  parameter int unsigned DW = DATA_W,
  parameter int unsigned PW = PC_W
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic issue,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand_byte,
  // final instruction byte; the direct loop form carries its address in operand_byte
  input wire logic [7:0] rel_byte,
  input wire logic [DW-1:0] acc_in,
  input wire logic [DW-1:0] aux_in,
  input wire logic [DW-1:0] wreg_in,
  input wire logic [DW-1:0] ram_in,
  input wire logic [DW-1:0] port_latch_in,
  input wire logic [DW-1:0] ptr_in,
  input wire logic carry_in,
  input wire logic half_carry_flag_in,
  input wire logic signed_excess_flag_in,
  input wire logic [PW-1:0] pc_next_in,
  output logic busy,
  output logic done,
  output logic illegal,
  output logic acc_we,
  output logic [DW-1:0] acc_out,
  output logic aux_we,
  output logic [DW-1:0] aux_out,
  output logic wreg_we,
  output logic [2:0] wreg_sel,
  output logic [DW-1:0] wreg_out,
  output logic mem_we,
  output logic [7:0] mem_addr,
  output logic [DW-1:0] mem_out,
  output logic carry_we,
  output logic carry_out,
  output logic excess_we,
  output logic signed_excess_flag_out,
  output logic branch_take,
  output logic [PW-1:0] branch_target
);
  typedef struct packed {
    bda_state_t st;
    logic busy;
    logic done;
    logic illegal;
    logic acc_we;
    logic [DW-1:0] acc;
    logic aux_we;
    logic [DW-1:0] aux;
    logic wreg_we;
    logic [2:0] wsel;
    logic [DW-1:0] wreg;
    logic mem_we;
    logic [7:0] addr;
    logic [DW-1:0] mem;
    logic carry_we;
    logic carry;
    logic excess_we;
    logic excess;
    logic br;
    logic [PW-1:0] tgt;
    logic div_start;
    logic zero_div;
  } bda_st_t;

  bda_st_t s_q;
  bda_st_t s_d;
  bda_div_if dv ();

  bda_divider u_div (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .dv(dv)
  );

  assign dv.start = s_q.div_start;
  assign dv.dividend = acc_in;
  assign dv.divisor = aux_in;

  logic [8:0] da_lo;
  logic [8:0] da_hi;
  logic da_c;
  logic [DW-1:0] dec_src;
  logic [DW-1:0] dec_val;
  logic dec_cls;
  bda_src_t dec_kind;
  logic is_loop;

  always_comb begin
    // low then high correction, carry only ever raised
    da_lo = {1'b0, acc_in};
    if (acc_in[3:0] > BCD_LIMIT || half_carry_flag_in) begin // RULE_01
      da_lo = {1'b0, acc_in} + {5'h00, BCD_FIX};
    end
    da_c = carry_in | da_lo[8]; // RULE_04
    da_hi = {1'b0, da_lo[7:0]};
    if (da_lo[7:4] > BCD_LIMIT || da_c) begin // RULE_02
      da_hi = {1'b0, da_lo[7:0]} + {1'b0, BCD_FIX, 4'h0};
    end
  end

  always_comb begin
    dec_cls = 1'b1;
    is_loop = 1'b0;
    dec_kind = BDA_SRC_ACC;
    if (opcode == OPC_DEC_ACC) begin // RULE_06
      dec_kind = BDA_SRC_ACC;
    end else if (opcode == OPC_DEC_DIRECT) begin // RULE_08
      dec_kind = BDA_SRC_DIRECT;
    end else if ((opcode & MASK_PTR) == OPC_DEC_PTR) begin
      dec_kind = BDA_SRC_PTR;
    end else if ((opcode & MASK_WREG) == OPC_DEC_WREG) begin
      dec_kind = BDA_SRC_WREG;
    end else if ((opcode & MASK_WREG) == OPC_LOOP_WREG) begin // RULE_14
      dec_kind = BDA_SRC_WREG;
      is_loop = 1'b1;
    end else if (opcode == OPC_LOOP_DIRECT) begin // RULE_14
      dec_kind = BDA_SRC_DIRECT;
      is_loop = 1'b1;
    end else begin
      dec_cls = 1'b0;
    end
    unique case (dec_kind)
      BDA_SRC_ACC: dec_src = acc_in;
      BDA_SRC_WREG: dec_src = wreg_in;
      // ports keep the latched value so read-modify-write ignores pin loading
      BDA_SRC_DIRECT: dec_src = (operand_byte >= SFR_BASE) ? port_latch_in : ram_in; // RULE_07
      BDA_SRC_PTR: dec_src = ram_in;
    endcase
    dec_val = dec_src - BYTE_ONE; // RULE_05 RULE_12
  end

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.illegal = 1'b0;
    s_d.acc_we = 1'b0;
    s_d.aux_we = 1'b0;
    s_d.wreg_we = 1'b0;
    s_d.mem_we = 1'b0;
    s_d.carry_we = 1'b0;
    s_d.excess_we = 1'b0;
    s_d.br = 1'b0;
    s_d.div_start = 1'b0;
    unique case (s_q.st)
      BDA_IDLE: begin
        if (issue) begin
          if (opcode == OPC_DECIMAL_ADJUST) begin
            s_d.acc_we = 1'b1;
            s_d.acc = da_hi[7:0];
            s_d.carry_we = 1'b1;
            s_d.carry = da_c | da_hi[8]; // RULE_03 RULE_04
            s_d.done = 1'b1;
          end else if (opcode == OPC_QUOTIENT) begin // RULE_09
            s_d.st = BDA_DIV;
            s_d.busy = 1'b1;
            s_d.div_start = 1'b1;
            s_d.zero_div = (aux_in == '0);
          end else if (dec_cls) begin
            s_d.done = 1'b1;
            s_d.wsel = opcode[2:0];
            s_d.addr = (dec_kind == BDA_SRC_PTR) ? ptr_in : operand_byte;
            unique case (dec_kind)
              BDA_SRC_ACC: begin
                s_d.acc_we = 1'b1;
                s_d.acc = dec_val;
              end
              BDA_SRC_WREG: begin
                s_d.wreg_we = 1'b1;
                s_d.wreg = dec_val;
              end
              BDA_SRC_DIRECT, BDA_SRC_PTR: begin
                s_d.mem_we = 1'b1;
                s_d.mem = dec_val;
              end
            endcase
            if (is_loop) begin
              s_d.br = (dec_val != '0); // RULE_12
              s_d.tgt = pc_next_in + PW'({{(PW-8){rel_byte[7]}}, rel_byte}); // RULE_13
            end
          end else begin
            s_d.illegal = 1'b1;
          end
        end
      end
      BDA_DIV: begin
        if (dv.done) begin
          s_d.st = BDA_WB;
        end
      end
      BDA_WB: begin
        // both halves land in one cycle so no partial result is seen
        s_d.acc_we = 1'b1; // RULE_15
        s_d.aux_we = 1'b1;
        s_d.acc = dv.quotient; // RULE_09
        s_d.aux = dv.remainder;
        s_d.carry_we = 1'b1;
        s_d.carry = 1'b0; // RULE_10 RULE_11
        s_d.excess_we = 1'b1;
        s_d.excess = s_q.zero_div; // RULE_10 RULE_11
        s_d.st = BDA_DONE;
      end
      BDA_DONE: begin
        s_d.done = 1'b1;
        s_d.busy = 1'b0;
        s_d.st = BDA_IDLE;
      end
      default: s_d.st = BDA_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '{st: BDA_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = s_q.busy;
  assign done = s_q.done;
  assign illegal = s_q.illegal;
  assign acc_we = s_q.acc_we;
  assign acc_out = s_q.acc;
  assign aux_we = s_q.aux_we;
  assign aux_out = s_q.aux;
  assign wreg_we = s_q.wreg_we;
  assign wreg_sel = s_q.wsel;
  assign wreg_out = s_q.wreg;
  assign mem_we = s_q.mem_we;
  assign mem_addr = s_q.addr;
  assign mem_out = s_q.mem;
  assign carry_we = s_q.carry_we;
  assign carry_out = s_q.carry;
  assign excess_we = s_q.excess_we;
  assign signed_excess_flag_out = s_q.excess;
  assign branch_take = s_q.br;
  assign branch_target = s_q.tgt;
endmodule : bda_alu

// ==== hdl/bda_pkg.sv ====
package bda_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PC_W = 16;
  // opcode patterns and masks
  localparam logic [7:0] OPC_DECIMAL_ADJUST = 8'hD4;
  localparam logic [7:0] OPC_DEC_ACC = 8'h14;
  localparam logic [7:0] OPC_DEC_DIRECT = 8'h15;
  localparam logic [7:0] OPC_DEC_PTR = 8'h16;
  localparam logic [7:0] MASK_PTR = 8'hFE;
  localparam logic [7:0] OPC_DEC_WREG = 8'h18;
  localparam logic [7:0] OPC_LOOP_WREG = 8'hD8;
  localparam logic [7:0] MASK_WREG = 8'hF8;
  localparam logic [7:0] OPC_QUOTIENT = 8'h84;
  localparam logic [7:0] OPC_LOOP_DIRECT = 8'hD5;
  localparam logic [3:0] BCD_LIMIT = 4'h9;
  localparam logic [3:0] BCD_FIX = 4'h6;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  // sfr space begins here; port latches live above it
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam int unsigned DIV_STEPS = 8;
  localparam logic [3:0] DIV_CNT_W0 = 4'h0;

  typedef enum logic [3:0] {
    BDA_IDLE = 4'b0001,
    BDA_DIV = 4'b0010,
    BDA_DONE = 4'b0100,
    BDA_WB = 4'b1000
  } bda_state_t;

  // operand source of a byte decrement
  typedef enum logic [1:0] {
    BDA_SRC_ACC = 2'h0,
    BDA_SRC_WREG = 2'h1,
    BDA_SRC_DIRECT = 2'h2,
    BDA_SRC_PTR = 2'h3
  } bda_src_t;
endpackage : bda_pkg

// ==== hdl/bda_div_if.sv ====
interface bda_div_if;
  import bda_pkg::*;
  logic start;
  logic [7:0] dividend;
  logic [7:0] divisor;
  logic done;
  logic [7:0] quotient;
  logic [7:0] remainder;
  modport ctrl (output start, output dividend, output divisor,
    input done, input quotient, input remainder);
  modport unit (input start, input dividend, input divisor,
    output done, output quotient, output remainder);
endinterface : bda_div_if

// ==== hdl/bda_divider.sv ====
module bda_divider
  import bda_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  bda_div_if.unit dv
);
  typedef struct packed {
    logic busy;
    logic [3:0] cnt;
    logic [7:0] rem;
    logic [7:0] quo;
    logic [7:0] dsr;
    logic done;
  } bda_div_st_t;

  bda_div_st_t s_q;
  bda_div_st_t s_d;
  logic [8:0] trial;

  // restoring division, one quotient bit per clock
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    trial = {s_q.rem, s_q.quo[7]} - {1'b0, s_q.dsr};
    if (!s_q.busy && dv.start) begin
      s_d.busy = 1'b1;
      s_d.cnt = DIV_CNT_W0;
      s_d.rem = '0;
      s_d.quo = dv.dividend;
      s_d.dsr = dv.divisor;
    end else if (s_q.busy) begin
      if (!trial[8]) begin
        s_d.rem = trial[7:0];
      end else begin
        s_d.rem = {s_q.rem[6:0], s_q.quo[7]};
      end
      s_d.quo = {s_q.quo[6:0], ~trial[8]};
      s_d.cnt = s_q.cnt + 4'h1;
      if (s_q.cnt == 4'(DIV_STEPS - 1)) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dv.done = s_q.done;
  assign dv.quotient = s_q.quo;
  assign dv.remainder = s_q.rem;
endmodule : bda_divider

// ==== tb/bda_alu_asserts.sv ====
module bda_alu_asserts
  import bda_pkg::*;
(
  input wire logic clk_sys, arst_n, issue, half_carry_flag_in, carry_in, busy, done, illegal,
  input wire logic acc_we, aux_we, wreg_we, mem_we, carry_we, carry_out, excess_we,
  input wire logic signed_excess_flag_out, branch_take,
  input wire logic [7:0] opcode, operand_byte, acc_in, aux_in, wreg_in, ram_in, port_latch_in,
  input wire logic [7:0] rel_byte, acc_out, wreg_out, mem_addr, mem_out,
  input wire logic [15:0] pc_next_in, branch_target
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic go;
  assign go = issue && !busy;

  // carry only ever gathers, never drops, across both steps
  function automatic logic [8:0] da_f(logic [7:0] a, logic hc, logic c);
    logic [8:0] s;
    logic cy;
    s = {1'b0, a};
    cy = c;
    if (s[3:0] > 4'h9 || hc) s = s + 9'h006;
    cy = cy | s[8];
    if (s[7:4] > 4'h9 || cy) s = {1'b0, s[7:0]} + 9'h060;
    return {cy | s[8], s[7:0]};
  endfunction : da_f

  da_result_a: assert property (go && opcode == 8'hd4 |=> acc_we && carry_we &&
    {carry_out, acc_out} == da_f($past(acc_in), $past(half_carry_flag_in), $past(carry_in)))
    else $error("adjust result wrong");
  da_flags_a: assert property (go && opcode == 8'hd4 && carry_in |=> carry_out && !excess_we)
    else $error("adjust flags wrong");
  dec_acc_a: assert property (go && opcode == 8'h14 |=> acc_we && !carry_we && !excess_we &&
    acc_out == $past(acc_in) - 8'h01) else $error("acc decrement wrong");
  dec_direct_a: assert property (go && opcode == 8'h15 |=> mem_we &&
    mem_addr == $past(operand_byte) && mem_out == (($past(operand_byte) >= 8'h80) ?
    $past(port_latch_in) : $past(ram_in)) - 8'h01) else $error("direct decrement wrong");
  div_timing_a: assert property (go && opcode == 8'h84 |=>
    busy [*8] ##1 busy [*3] ##1 (busy && acc_we && aux_we && carry_we && !carry_out) ##1
    (done && !busy)) else $error("divide timing wrong");
  div_zero_a: assert property (go && opcode == 8'h84 && aux_in == 8'h00 |=>
    ##11 excess_we && signed_excess_flag_out) else $error("zero divisor flag wrong");
  loop_count_a: assert property (go && opcode[7:3] == 5'h1b |=> wreg_we &&
    wreg_out == $past(wreg_in) - 8'h01 && branch_take == (wreg_out != 8'h00))
    else $error("loop count wrong");
  loop_target_a: assert property (go && (opcode[7:3] == 5'h1b || opcode == 8'hd5) |=>
    !branch_take || branch_target == $past(pc_next_in) + 16'($signed($past(rel_byte))))
    else $error("branch target wrong");
  ptr_loop_a: assert property (go && opcode == 8'hd6 |=> illegal && !wreg_we && !mem_we)
    else $error("pointer loop form accepted");
endmodule : bda_alu_asserts

bind bda_alu bda_alu_asserts chk (.*);

// ==== tb/bda_alu_bench.sv ====
module bda_alu_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, arst_n, issue, carry_in, half_carry_flag_in, signed_excess_flag_in;
  logic [7:0] opcode, operand_byte, acc_in, aux_in, wreg_in, ram_in, port_latch_in, ptr_in;
  logic [15:0] pc_next_in, branch_target, g_tgt;
  logic busy, done, illegal, acc_we, aux_we, wreg_we, mem_we, carry_we, carry_out, excess_we;
  logic signed_excess_flag_out, branch_take, g_c, g_ov, g_br, g_ill;
  logic [2:0] wreg_sel, g_sel;
  logic [7:0] rel_byte;
  logic [5:0] g_we;
  logic [7:0] acc_out, aux_out, wreg_out, mem_addr, mem_out, g_val, g_aux, g_addr;
  int n_errors = 0;
  int checked = 0;

  bda_alu uut (.*);

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_flag(input logic got, input logic exp);
    chk_val({15'h0000, got}, {15'h0000, exp});
  endtask : chk_flag

  task automatic tally_and_finish();
    if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // pulses last one cycle, so every cycle is gathered until done
  task automatic run(input logic [7:0] opc, input logic [7:0] opb);
    int i;
    @(posedge clk_sys);
    issue <= 1'b1;
    opcode <= opc;
    operand_byte <= opb;
    @(posedge clk_sys);
    issue <= 1'b0;
    {g_we, g_br, g_ill} = '0;
    // stale values from an earlier call must not pass for a missing write
    {g_val, g_aux, g_addr, g_sel, g_tgt} = 'x;
    g_c = carry_in;
    g_ov = signed_excess_flag_in;
    for (i = 0; i < 20; i++) begin
      #1;
      g_we = g_we | {acc_we, aux_we, wreg_we, mem_we, carry_we, excess_we};
      if (acc_we) g_val = acc_out;
      if (wreg_we) {g_val, g_sel} = {wreg_out, wreg_sel};
      if (mem_we) {g_val, g_addr} = {mem_out, mem_addr};
      if (aux_we) g_aux = aux_out;
      if (carry_we) g_c = carry_out;
      if (excess_we) g_ov = signed_excess_flag_out;
      if (branch_take) {g_br, g_tgt} = {1'b1, branch_target};
      if (illegal) g_ill = 1'b1;
      if (done || illegal) break;
      @(posedge clk_sys);
    end
    if (i == 20) begin
      n_errors++;
      tally_and_finish();
    end
  endtask : run

  task automatic t_adjust();
    logic [7:0] a_v [5] = '{8'hbe, 8'hc9, 8'h00, 8'h19, 8'h9a};
    logic [7:0] r_v [5] = '{8'h24, 8'h29, 8'h60, 8'h1f, 8'h00};
    logic [4:0] hc_v = 5'h08;
    logic [4:0] c_v = 5'h04;
    logic [4:0] e_v = 5'h17;
    for (int i = 0; i < 5; i++) begin
      acc_in <= a_v[i];
      half_carry_flag_in <= hc_v[i];
      carry_in <= c_v[i];
      run(8'hd4, 8'h00);
      chk_val(g_val, r_v[i]);
      chk_flag(g_c, e_v[i]);
      chk_flag(g_we[0], 1'b0);
    end
  endtask : t_adjust

  task automatic t_count_down();
    logic [7:0] op_v [5] = '{8'h14, 8'h1f, 8'h15, 8'h15, 8'h17};
    logic [7:0] ob_v [5] = '{8'h00, 8'h00, 8'h7e, 8'h90, 8'h00};
    logic [7:0] ex_v [5] = '{8'hff, 8'h7e, 8'ha1, 8'h5c, 8'ha1};
    logic [7:0] ad_v [5] = '{8'h00, 8'h00, 8'h7e, 8'h90, 8'h7e};
    acc_in <= 8'h00;
    wreg_in <= 8'h7f;
    ram_in <= 8'ha2;
    port_latch_in <= 8'h5d;
    ptr_in <= 8'h7e;
    for (int i = 0; i < 5; i++) begin
      run(op_v[i], ob_v[i]);
      chk_val(g_val, ex_v[i]);
      chk_val(g_we[1:0], 2'h0);
      if (i == 1) chk_val(g_sel, 3'h7);
      if (i > 1) chk_val(g_addr, ad_v[i]);
    end
  endtask : t_count_down

  task automatic t_quotient();
    logic [7:0] a_v [2] = '{8'hfb, 8'hff};
    logic [7:0] b_v [2] = '{8'h12, 8'h01};
    logic [7:0] q_v [2] = '{8'h0d, 8'hff};
    logic [7:0] r_v [2] = '{8'h11, 8'h00};
    carry_in <= 1'b1;
    signed_excess_flag_in <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      acc_in <= a_v[i];
      aux_in <= b_v[i];
      run(8'h84, 8'h00);
      chk_val({g_val, g_aux}, {q_v[i], r_v[i]});
      chk_val({g_c, g_ov}, 2'h0);
    end
    aux_in <= 8'h00;
    signed_excess_flag_in <= 1'b0;
    run(8'h84, 8'h00);
    chk_val({g_c, g_ov}, 2'h1);
  endtask : t_quotient

  task automatic t_loop();
    logic [7:0] op_v [4] = '{8'hd5, 8'hd5, 8'hda, 8'hd9};
    logic [7:0] ob_v [4] = '{8'h40, 8'h50, 8'hfe, 8'h05};
    logic [7:0] s_v [4] = '{8'h01, 8'h70, 8'h00, 8'h02};
    logic [7:0] ex_v [4] = '{8'h00, 8'h6f, 8'hff, 8'h01};
    logic [7:0] rb_v [4] = '{8'h00, 8'h10, 8'hfe, 8'h05};
    logic [15:0] tg_v [4] = '{16'h0000, 16'h1244, 16'h1232, 16'h1239};
    logic [3:0] br_v = 4'he;
    pc_next_in <= 16'h1234;
    for (int i = 0; i < 4; i++) begin
      ram_in <= s_v[i];
      wreg_in <= s_v[i];
      rel_byte <= rb_v[i];
      run(op_v[i], ob_v[i]);
      chk_val(g_val, ex_v[i]);
      chk_flag(g_br, br_v[i]);
      chk_val(g_we[1:0], 2'h0);
      if (i > 0) chk_val(g_tgt, tg_v[i]);
      if (i > 1) chk_val(g_sel, op_v[i][2:0]);
    end
    run(8'hd6, 8'h00);
    chk_flag(g_ill, 1'b1);
    chk_val(g_we, 6'h00);
  endtask : t_loop

  task automatic t_reset();
    acc_in <= 8'h40;
    aux_in <= 8'h03;
    @(posedge clk_sys);
    issue <= 1'b1;
    opcode <= 8'h84;
    @(posedge clk_sys);
    issue <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk_flag(busy, 1'b1);
    arst_n <= 1'b0;
    #1;
    // an aborted divide must leave nothing half written
    chk_val({busy, done, acc_we, aux_we, carry_we, excess_we, branch_take, illegal}, 16'h0000);
    chk_val({acc_out, aux_out}, 16'h0000);
    @(posedge clk_sys);
    arst_n <= 1'b1;
    run(8'h14, 8'h00);
    chk_val(g_val, 8'h3f);
  endtask : t_reset

  initial begin
    {arst_n, issue, carry_in, half_carry_flag_in, signed_excess_flag_in} = '0;
    {opcode, operand_byte, acc_in, aux_in, wreg_in, ram_in, port_latch_in, ptr_in} = '0;
    pc_next_in = 16'h0000;
    rel_byte = 8'h00;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_adjust();
    t_count_down();
    t_quotient();
    t_loop();
    t_reset();
    tally_and_finish();
  end
endmodule : bda_alu_bench
